/* File: pkg/wakeup_ctrl_pkg.sv */
package wakeup_ctrl_pkg;

	// line counts
	localparam int NUM_LINES = 36;                      // all edge detector lines
	localparam int NUM_EXT   = 16;                      // pin-routed lines, indices 0..15
	localparam int NUM_INT   = 20;                      // peripheral lines, indices 16..35
	localparam int NUM_GPIO  = 114;                     // selectable pin inputs
	localparam int SEL_W     = 7;                       // width of one pin select
	localparam int HI_W      = NUM_LINES - 32;          // line bits held in the upper word
	localparam int SEL_STEP  = 8;                       // select field stride in a word
	localparam int SEL_PER_W = 4;                       // select fields per word
	localparam int SEL_WORDS = NUM_EXT / SEL_PER_W;     // select words

	// register byte offsets
	localparam logic [7:0] OFS_IMASK_LO = 8'h00;        // interrupt mask, lines 31..0
	localparam logic [7:0] OFS_IMASK_HI = 8'h04;        // interrupt mask, lines 35..32
	localparam logic [7:0] OFS_EMASK_LO = 8'h08;        // event mask, lines 31..0
	localparam logic [7:0] OFS_EMASK_HI = 8'h0c;        // event mask, lines 35..32
	localparam logic [7:0] OFS_RISE_LO  = 8'h10;        // rising trigger enable
	localparam logic [7:0] OFS_RISE_HI  = 8'h14;
	localparam logic [7:0] OFS_FALL_LO  = 8'h18;        // falling trigger enable
	localparam logic [7:0] OFS_FALL_HI  = 8'h1c;
	localparam logic [7:0] OFS_PEND_LO  = 8'h20;        // pending, write one to clear
	localparam logic [7:0] OFS_PEND_HI  = 8'h24;
	localparam logic [7:0] OFS_SEL0     = 8'h30;        // first pin select word
	localparam int         ADDR_LSB     = 2;            // word index starts here
	localparam int         ADDR_W       = 8;            // decoded address bits

	// reset values
	localparam logic [NUM_LINES-1:0] LINES_RST = 36'h0_0000_0000;
	localparam logic [31:0]          WORD_RST  = 32'h0000_0000;
	localparam logic [31:0]          SEL_MASK  = 32'h7f7f_7f7f; // bit 7 of each field reserved

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// software configuration of all lines, carried together
	typedef struct packed {
		logic [NUM_LINES-1:0] int_mask;             // 1 lets a pending line interrupt
		logic [NUM_LINES-1:0] evt_mask;             // 1 lets an edge make an event pulse
		logic [NUM_LINES-1:0] rise_en;              // rising edge selected
		logic [NUM_LINES-1:0] fall_en;              // falling edge selected
	} line_cfg_t;

	typedef logic [NUM_LINES-1:0] line_vec_t;

endpackage : wakeup_ctrl_pkg

/* File: hdl/edge_capture_line.sv */
`timescale 1ns/10ps
// one detector line: edges are latched by the line itself, so a pulse
// shorter than a clock period still flips a toggle that the clock then sees
module edge_capture_line (
	input  wire logic line_in,   // raw line, any timing
	input  wire logic aclk,      // system clock
	input  wire logic aresetn,   // system reset, active low
	input  wire logic clk_en,    // freezes clocked state while low
	input  wire logic rise_en,   // report rising edges
	input  wire logic fall_en,   // report falling edges
	output logic      edge_hit   // one-cycle selected edge
);

	logic rise_tgl_reg;          // flips on each rising edge of the line
	logic fall_tgl_reg;          // flips on each falling edge of the line
	logic rise_s1_reg;           // first synchroniser stage
	logic rise_s2_reg;           // second synchroniser stage
	logic rise_last_reg;         // previous synchronised value
	logic fall_s1_reg;
	logic fall_s2_reg;
	logic fall_last_reg;
	wire  rise_seen;             // a rising toggle arrived
	wire  fall_seen;             // a falling toggle arrived

	// latch rising edges without the clock; reset is a constant only
	always_ff @(posedge line_in or negedge aresetn) begin
		if (!aresetn) begin
			rise_tgl_reg <= 1'b0;
		end else begin
			rise_tgl_reg <= ~rise_tgl_reg;
		end
	end

	// latch falling edges without the clock
	always_ff @(negedge line_in or negedge aresetn) begin
		if (!aresetn) begin
			fall_tgl_reg <= 1'b0;
		end else begin
			fall_tgl_reg <= ~fall_tgl_reg;
		end
	end

	// bring both toggles into the clock domain; stage one feeds stage two only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rise_s1_reg   <= 1'b0;
			rise_s2_reg   <= 1'b0;
			rise_last_reg <= 1'b0;
			fall_s1_reg   <= 1'b0;
			fall_s2_reg   <= 1'b0;
			fall_last_reg <= 1'b0;
		end else if (clk_en) begin
			rise_s1_reg   <= rise_tgl_reg;
			rise_s2_reg   <= rise_s1_reg;
			rise_last_reg <= rise_s2_reg;
			fall_s1_reg   <= fall_tgl_reg;
			fall_s2_reg   <= fall_s1_reg;
			fall_last_reg <= fall_s2_reg;
		end
	end

	// a change of toggle is one edge; two edges between two samples of stage one cancel
	assign rise_seen = rise_s2_reg ^ rise_last_reg;
	assign fall_seen = fall_s2_reg ^ fall_last_reg;
	assign edge_hit  = clk_en & ((rise_seen & rise_en) | (fall_seen & fall_en));

endmodule : edge_capture_line

/* File: hdl/extended_edge_event_controller.sv */
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
// Operation
// - thirty-six lines, each interrupt or event source
// - per line rising, falling or both edges
// - per line mask, independent of others
// - pending bit per line holds until cleared
// - edges narrower than clock still captured
// - any of 114 pins routed per pin line
// - peripheral lines share detection and pending logic
// - unmasked request raises system wakeup
module extended_edge_event_controller (
	input  wire logic                                  aclk,          // system clock, 10 MHz
	input  wire logic                                  aresetn,       // sync reset, active low
	input  wire logic                                  clk_en,        // freezes clocked state while low
	input  wire logic [wakeup_ctrl_pkg::NUM_GPIO-1:0]  gpio_in,       // raw pin levels
	input  wire logic [wakeup_ctrl_pkg::NUM_INT-1:0]   periph_line,   // peripheral wakeup lines
	input  wire logic [31:0]                           s_axi_awaddr,  // write address
	input  wire logic                                  s_axi_awvalid, // write address valid
	output logic                                       s_axi_awready, // write address ready
	input  wire logic [31:0]                           s_axi_wdata,   // write data
	input  wire logic [3:0]                            s_axi_wstrb,   // write byte enables
	input  wire logic                                  s_axi_wvalid,  // write data valid
	output logic                                       s_axi_wready,  // write data ready
	output logic [1:0]                                 s_axi_bresp,   // write response
	output logic                                       s_axi_bvalid,  // write response valid
	input  wire logic                                  s_axi_bready,  // write response ready
	input  wire logic [31:0]                           s_axi_araddr,  // read address
	input  wire logic                                  s_axi_arvalid, // read address valid
	output logic                                       s_axi_arready, // read address ready
	output logic [31:0]                                s_axi_rdata,   // read data
	output logic [1:0]                                 s_axi_rresp,   // read response
	output logic                                       s_axi_rvalid,  // read data valid
	input  wire logic                                  s_axi_rready,  // read data ready
	output logic [wakeup_ctrl_pkg::NUM_LINES-1:0]      irq_lines,     // per line request to vector unit
	output logic                                       irq,           // any unmasked pending line
	output logic                                       event_pulse,   // one-cycle event request
	output logic                                       wakeup         // system wakeup level
);
	import wakeup_ctrl_pkg::*;

	// configuration and status state
	line_cfg_t         cfg_reg;                     // masks and trigger selects
	line_vec_t         pend_reg;                    // sticky pending bits
	line_vec_t         pend_next;                   // next pending value
	logic [31:0]       sel_reg [SEL_WORDS];         // pin select words
	logic [NUM_GPIO-1:0] gpio_s1_reg;               // pin sync stage one
	logic [NUM_GPIO-1:0] gpio_s2_reg;               // pin sync stage two (unused for capture)

	// output registers
	line_vec_t         irq_lines_reg;
	logic              irq_reg;
	logic              event_pulse_reg;
	logic              wakeup_reg;

	// bus state
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic              aw_held_reg;                 // write address taken
	logic              w_held_reg;                  // write data taken
	logic [ADDR_W-1:0] waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;

	// line sources and detections
	wire  [NUM_EXT-1:0] ext_line;                   // pins after routing
	line_vec_t          line_src;                   // all 36 sources
	line_vec_t          edge_hit;                   // selected edges this cycle

	// pin routing: the capture must see the raw pin, so the mux stays
	// ahead of any sampling; changing a select can itself look like an edge
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_route
			wire [SEL_W-1:0] sel_f; // select for this line
			assign sel_f = sel_reg[gi / SEL_PER_W][(gi % SEL_PER_W) * SEL_STEP +: SEL_W];
			assign ext_line[gi] = (32'(sel_f) < NUM_GPIO) ? gpio_in[sel_f] : 1'b0;
		end
	endgenerate

	// peripheral lines sit above the pin lines
	assign line_src = {periph_line, ext_line};

	// one detector per line
	generate
		for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
			edge_capture_line u_line (
				.line_in  (line_src[gi]),
				.aclk     (aclk),
				.aresetn  (aresetn),
				.clk_en   (clk_en),
				.rise_en  (cfg_reg.rise_en[gi]),
				.fall_en  (cfg_reg.fall_en[gi]),
				.edge_hit (edge_hit[gi])
			);
		end
	endgenerate

	// write decode, valid once both halves of a write are held
	wire               wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire [ADDR_W-1:0]  wa       = waddr_reg;
	wire               wr_sel   = (wa >= OFS_SEL0) && (wa < OFS_SEL0 + 8'(SEL_WORDS * 4));
	wire [1:0]         wr_sidx  = 2'((wa - OFS_SEL0) >> ADDR_LSB);
	wire               wr_map   = (wa == OFS_IMASK_LO) | (wa == OFS_IMASK_HI)
	                            | (wa == OFS_EMASK_LO) | (wa == OFS_EMASK_HI)
	                            | (wa == OFS_RISE_LO)  | (wa == OFS_RISE_HI)
	                            | (wa == OFS_FALL_LO)  | (wa == OFS_FALL_HI)
	                            | (wa == OFS_PEND_LO)  | (wa == OFS_PEND_HI) | wr_sel;
	wire [31:0]        strb_m   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
	                               {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire [31:0]        wd_m     = wdata_reg & strb_m;

	// byte-lane merge of a word into a 36-bit line vector
	function automatic line_vec_t merge_lines(input line_vec_t old, input logic hi);
		line_vec_t res;
		res = old;
		if (hi) begin
			res[NUM_LINES-1:32] = (old[NUM_LINES-1:32] & ~strb_m[HI_W-1:0])
			                    | wd_m[HI_W-1:0];
		end else begin
			res[31:0] = (old[31:0] & ~strb_m) | wd_m;
		end
		return res;
	endfunction : merge_lines

	// clear bits for the pending register, write one to clear
	line_vec_t pend_clr;
	assign pend_clr = !wr_fire ? LINES_RST
	                : (wa == OFS_PEND_LO) ? {{HI_W{1'b0}}, wd_m}
	                : (wa == OFS_PEND_HI) ? {wd_m[HI_W-1:0], 32'h0000_0000}
	                : LINES_RST;

	// a new edge is set after the clear, so it survives a same-cycle clear
	assign pend_next = (pend_reg & ~pend_clr) | edge_hit;

	// read decode, taken straight from the address bus on acceptance
	wire [ADDR_W-1:0] ra      = s_axi_araddr[ADDR_W-1:0];
	wire              rd_sel  = (ra >= OFS_SEL0) && (ra < OFS_SEL0 + 8'(SEL_WORDS * 4));
	wire [1:0]        rd_sidx = 2'((ra - OFS_SEL0) >> ADDR_LSB);
	wire [31:0]       hi_pad  = 32'h0000_0000;
	logic [31:0]      rd_word;
	logic             rd_ok;

	// read mux; upper bits of the high words read as zero
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = WORD_RST;
		case (ra)
			OFS_IMASK_LO: rd_word = cfg_reg.int_mask[31:0];
			OFS_IMASK_HI: rd_word = {hi_pad[31:HI_W], cfg_reg.int_mask[NUM_LINES-1:32]};
			OFS_EMASK_LO: rd_word = cfg_reg.evt_mask[31:0];
			OFS_EMASK_HI: rd_word = {hi_pad[31:HI_W], cfg_reg.evt_mask[NUM_LINES-1:32]};
			OFS_RISE_LO:  rd_word = cfg_reg.rise_en[31:0];
			OFS_RISE_HI:  rd_word = {hi_pad[31:HI_W], cfg_reg.rise_en[NUM_LINES-1:32]};
			OFS_FALL_LO:  rd_word = cfg_reg.fall_en[31:0];
			OFS_FALL_HI:  rd_word = {hi_pad[31:HI_W], cfg_reg.fall_en[NUM_LINES-1:32]};
			OFS_PEND_LO:  rd_word = pend_reg[31:0];
			OFS_PEND_HI:  rd_word = {hi_pad[31:HI_W], pend_reg[NUM_LINES-1:32]};
			default: begin
				// select words, else unmapped
				if (rd_sel) begin
					rd_word = sel_reg[rd_sidx];
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// requests toward the vector unit and wakeup logic
	line_vec_t irq_next;
	wire       evt_next;
	assign irq_next = pend_next & cfg_reg.int_mask;
	assign evt_next = |(edge_hit & cfg_reg.evt_mask);

	// configuration registers, written only on a mapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= '{LINES_RST, LINES_RST, LINES_RST, LINES_RST};
			for (int i = 0; i < SEL_WORDS; i++) begin
				sel_reg[i] <= WORD_RST;
			end
		end else if (clk_en && wr_fire) begin
			// each word goes to its own field
			case (wa)
				OFS_IMASK_LO: cfg_reg.int_mask <= merge_lines(cfg_reg.int_mask, 1'b0);
				OFS_IMASK_HI: cfg_reg.int_mask <= merge_lines(cfg_reg.int_mask, 1'b1);
				OFS_EMASK_LO: cfg_reg.evt_mask <= merge_lines(cfg_reg.evt_mask, 1'b0);
				OFS_EMASK_HI: cfg_reg.evt_mask <= merge_lines(cfg_reg.evt_mask, 1'b1);
				OFS_RISE_LO:  cfg_reg.rise_en  <= merge_lines(cfg_reg.rise_en, 1'b0);
				OFS_RISE_HI:  cfg_reg.rise_en  <= merge_lines(cfg_reg.rise_en, 1'b1);
				OFS_FALL_LO:  cfg_reg.fall_en  <= merge_lines(cfg_reg.fall_en, 1'b0);
				OFS_FALL_HI:  cfg_reg.fall_en  <= merge_lines(cfg_reg.fall_en, 1'b1);
				default: begin
					// reserved select bits never store
					if (wr_sel) begin
						sel_reg[wr_sidx] <= ((sel_reg[wr_sidx] & ~strb_m) | wd_m) & SEL_MASK;
					end
				end
			endcase
		end
	end

	// pending bits and request outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_reg        <= LINES_RST;
			irq_lines_reg   <= LINES_RST;
			irq_reg         <= 1'b0;
			event_pulse_reg <= 1'b0;
			wakeup_reg      <= 1'b0;
		end else if (clk_en) begin
			pend_reg        <= pend_next;
			irq_lines_reg   <= irq_next;
			irq_reg         <= |irq_next;
			event_pulse_reg <= evt_next;
			// wake on any unmasked interrupt or event; needs aclk running in stop
			wakeup_reg      <= (|irq_next) | evt_next;
		end
	end

	// pins are also synchronised for a clean level view; not used for capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gpio_s1_reg <= '0;
			gpio_s2_reg <= '0;
		end else if (clk_en) begin
			gpio_s1_reg <= gpio_in;
			gpio_s2_reg <= gpio_s1_reg;
		end
	end

	// write channel: address and data taken in either order, then one response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			waddr_reg   <= '0;
			wdata_reg   <= WORD_RST;
			wstrb_reg   <= '0;
		end else if (clk_en) begin
			// address half
			if (awready_reg && s_axi_awvalid) begin
				awready_reg <= 1'b0;
				aw_held_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr[ADDR_W-1:0];
			end
			// data half
			if (wready_reg && s_axi_wvalid) begin
				wready_reg <= 1'b0;
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			// both held: commit and answer next cycle
			if (wr_fire) begin
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_map ? RESP_OKAY : RESP_SLVERR;
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
			// response taken: reopen both halves
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// read channel: one read at a time, data registered on acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= WORD_RST;
			rresp_reg   <= RESP_OKAY;
		end else if (clk_en) begin
			if (arready_reg && s_axi_arvalid) begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rd_word;
				rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign irq_lines     = irq_lines_reg;
	assign irq           = irq_reg;
	assign event_pulse   = event_pulse_reg;
	assign wakeup        = wakeup_reg;

endmodule : extended_edge_event_controller

/* File: sim/wakeup_ctrl_asserts.sv */
`timescale 1ns/10ps
// pin level checks of the controller, bound into every instance
module wakeup_ctrl_asserts
	import wakeup_ctrl_pkg::*;
(
	input wire logic                                 aclk,          // system clock
	input wire logic                                 aresetn,       // sync reset, active low
	input wire logic                                 clk_en,        // run enable
	input wire logic                                 s_axi_awvalid, // write address valid
	input wire logic                                 s_axi_awready, // write address ready
	input wire logic                                 s_axi_wvalid,  // write data valid
	input wire logic                                 s_axi_wready,  // write data ready
	input wire logic [1:0]                           s_axi_bresp,   // write response
	input wire logic                                 s_axi_bvalid,  // write response valid
	input wire logic                                 s_axi_bready,  // write response ready
	input wire logic                                 s_axi_arvalid, // read address valid
	input wire logic                                 s_axi_arready, // read address ready
	input wire logic [31:0]                          s_axi_rdata,   // read data
	input wire logic [1:0]                           s_axi_rresp,   // read response
	input wire logic                                 s_axi_rvalid,  // read data valid
	input wire logic                                 s_axi_rready,  // read data ready
	input wire logic [wakeup_ctrl_pkg::NUM_LINES-1:0] irq_lines,    // per line requests
	input wire logic                                 irq,           // any request
	input wire logic                                 event_pulse,   // event request
	input wire logic                                 wakeup         // system wakeup
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// the summary line is the plain or of the per line requests
	irq_any_a: assert property (irq == (|irq_lines))
		else $error("irq differs from the line requests");
	// wakeup follows any interrupt or event request, never anything else
	wake_src_a: assert property (wakeup == (irq || event_pulse))
		else $error("wakeup does not match its sources");
	// a request drops only shortly after a register write landed
	irq_hold_a: assert property ((($past(irq_lines) & ~irq_lines) != '0)
		|-> (s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)))
		else $error("line request dropped without a write");
	// read answer comes right after the address is taken
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
		else $error("read answer late");
	// write answer comes two cycles after both halves are taken
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && clk_en |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	// refused reads carry no data
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("refused read returned data");
	// no new write accepted while a response is pending
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	evt_seen_c: cover property (event_pulse);
endmodule : wakeup_ctrl_asserts

bind extended_edge_event_controller wakeup_ctrl_asserts chk_u (.*);

/* File: sim/line_source_model.sv */
`timescale 1ns/10ps
// pins and peripheral lines facing the controller; all idle low
module line_source_model
	import wakeup_ctrl_pkg::*;
(
	output logic [wakeup_ctrl_pkg::NUM_GPIO-1:0] gpio_in,     // pin levels
	output logic [wakeup_ctrl_pkg::NUM_INT-1:0]  periph_line  // peripheral wakeup lines
);
	// quiet lines from time zero, so no edge is seen at release
	initial begin
		gpio_in = '0;
		periph_line = '0;
	end
	// index below the pin count is a pin, at or above it a peripheral
	task automatic set_line(input int idx, input logic lvl);
		if (idx < NUM_GPIO) gpio_in[idx] = lvl;
		else periph_line[idx-NUM_GPIO] = lvl;
	endtask : set_line
	// pulse shorter than a clock period, no clock relation at all
	task automatic pulse(input int idx, input int ns);
		set_line(idx, 1'b1);
		#(ns);
		set_line(idx, 1'b0);
	endtask : pulse
endmodule : line_source_model

/* File: sim/edge_event_wakeup_controller_tb.sv */
`timescale 1ns/10ps
// register bus driver, line stimulus and queued result checks
module edge_event_wakeup_controller_tb;
	import wakeup_ctrl_pkg::*;
	logic aclk, aresetn, clk_en, smp;
	logic [NUM_GPIO-1:0] gpio_in;
	logic [NUM_INT-1:0] periph_line;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, v;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	line_vec_t irq_lines, bk, bl;
	logic irq, event_pulse, wakeup;
	logic [39:0] rd_q[$], wr_q[$], ln_q[$];  // expected results, oldest first
	int num_errors, checks_done, cyc, evt_n, k, p, j;

	extended_edge_event_controller dut (.*);
	line_source_model src (.*);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask : cmp
	task automatic results();
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	// monitor samples mid-cycle, where a handshake of the next edge is settled
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) cmp(rd_q.pop_front(), 40'({s_axi_rdata, s_axi_rresp}));
		if (s_axi_bvalid && s_axi_bready) cmp(wr_q.pop_front(), 40'(s_axi_bresp));
		if (smp) cmp(ln_q.pop_front(), 40'({irq_lines, irq, wakeup}));
		if (event_pulse) evt_n++;
	end
	// hang guard, far above the fewer than a thousand cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask : wt
	// write: both halves offered together, response ready after a random delay
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n, dly;
		logic ta, tw, tb;
		n = 0;
		tb = 1'b0;
		dly = int'(rnd() % 3);
		wr_q.push_back(40'(r));
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid && s_axi_bready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
			else if (n == dly) s_axi_bready <= 1'b1;
			n++;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n, dly;
		logic ta, tr;
		n = 0;
		tr = 1'b0;
		dly = int'(rnd() % 3);
		rd_q.push_back(40'({d, r}));
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid && s_axi_rready;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
			else if (n == dly) s_axi_rready <= 1'b1;
			n++;
		end
	endtask : rd
	// line vectors span a low word and four bits of the high word
	task automatic cfg(input logic [7:0] a, input line_vec_t l);
		wr(a, l[31:0], RESP_OKAY);
		wr(a + 8'h04, {28'h0, l[35:32]}, RESP_OKAY);
	endtask : cfg
	task automatic rdv(input logic [7:0] a, input line_vec_t l);
		rd(a, l[31:0], RESP_OKAY);
		rd(a + 8'h04, {28'h0, l[35:32]}, RESP_OKAY);
	endtask : rdv
	task automatic chk(input line_vec_t l);
		ln_q.push_back({2'b0, l, |l, |l});
		@(posedge aclk);
		smp <= 1'b1;
		@(posedge aclk);
		smp <= 1'b0;
	endtask : chk
	// after an edge: request and pending as given, then all cleared
	task automatic seen(input line_vec_t l);
		wt(8);
		chk(l);
		rdv(OFS_PEND_LO, l);
		cfg(OFS_PEND_LO, '1);
		wt(2);
		chk('0);
	endtask : seen

	initial begin
		{aresetn, smp, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		clk_en = 1'b1;
		seed = 32'hb9a5;
		wt(2);
		aresetn <= 1'b1;
		// reset values everywhere, the gap words refused
		for (int a = 0; a < 64; a += 4)
			rd(a[7:0], 32'h0, (a == 40 || a == 44) ? RESP_SLVERR : RESP_OKAY);
		wr(8'h28, 32'hffff_ffff, RESP_SLVERR);
		rd(8'h28, 32'h0, RESP_SLVERR);
		// random round trip; high words keep four bits, selects seven per byte
		for (int a = 0; a < 64; a += 4) begin
			if (a < 32 || a >= 48) begin
				v = rnd();
				wr(a[7:0], v, RESP_OKAY);
				rd(a[7:0], v & (a >= 48 ? SEL_MASK : a[2] ? 32'hf : 32'hffff_ffff), RESP_OKAY);
				wr(a[7:0], 32'h0, RESP_OKAY);
			end
		end
		// one byte lane only: the other lanes keep their cleared value
		s_axi_wstrb <= 4'h2;
		wr(OFS_SEL0, 32'hffff_ffff, RESP_OKAY);
		rd(OFS_SEL0, 32'h0000_7f00, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		wr(OFS_SEL0, 32'h0, RESP_OKAY);
		// route a random pin to a random pin line, try each trigger choice
		k = int'(rnd() % NUM_EXT);
		p = int'(rnd() % NUM_GPIO);
		bk = line_vec_t'(1) << k;
		wr(OFS_SEL0 + 8'(k / 4 * 4), 32'(p) << (8 * (k % 4)), RESP_OKAY);
		cfg(OFS_IMASK_LO, bk);
		for (int m = 1; m < 4; m++) begin
			cfg(OFS_RISE_LO, m[0] ? bk : '0);
			cfg(OFS_FALL_LO, m[1] ? bk : '0);
			src.set_line(p, 1'b1);
			seen(m[0] ? bk : '0);
			src.set_line(p, 1'b0);
			seen(m[1] ? bk : '0);
		end
		// narrow pulse while frozen is still caught once running again
		cfg(OFS_FALL_LO, '0);
		@(posedge aclk);
		clk_en <= 1'b0;
		src.pulse(p, 30);
		wt(4);
		chk('0);
		@(posedge aclk);
		clk_en <= 1'b1;
		seen(bk);
		// peripheral line: pending and event, but its interrupt masked off
		j = int'(rnd() % NUM_INT);
		bl = line_vec_t'(1) << (NUM_EXT + j);
		cfg(OFS_RISE_LO, bk | bl);
		cfg(OFS_EMASK_LO, bl);
		evt_n = 0;
		src.set_line(p, 1'b1);
		src.set_line(NUM_GPIO + j, 1'b1);
		wt(8);
		chk(bk);
		rdv(OFS_PEND_LO, bk | bl);
		cmp(40'h1, 40'(evt_n));
		cfg(OFS_PEND_LO, bk);
		wt(2);
		chk('0);
		rdv(OFS_PEND_LO, bl);
		wt(4);
		results();
	end
endmodule : edge_event_wakeup_controller_tb
